// file: common/stp_consts.svh
// Offsets, field resets, mode codes and loop timing constants of the SOP tracking register bank
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH

// Register indices; byte address is four times the index
`define STP_IDX_ITER      10'h14F
`define STP_IDX_MODE      10'h154
`define STP_IDX_GAIN      10'h155
`define STP_IDX_DIR       10'h156
`define STP_IDX_EXP       10'h157
`define STP_IDX_DELAY     10'h158
`define STP_IDX_DITHER    10'h159
`define STP_IDX_PULLBACK  10'h15A
`define STP_IDX_TRACK     10'h15B

// Reset values
`define STP_RST_MODE      4'h0
`define STP_RST_GAIN      16'h0064
`define STP_RST_DIR       1'h0
`define STP_RST_EXP       4'h0
`define STP_RST_DELAY     13'h0000
`define STP_RST_DITHER    3'h2
`define STP_RST_PULLBACK  4'h1
`define STP_RST_TRACK     7'h00
`define STP_RST_ITER      8'h00

// Loop mode codes
`define STP_MODE_OFF      4'h0
`define STP_MODE_HOLD     4'h1
`define STP_MODE_TRACK    4'h3
`define STP_MODE_PDL_EXT  4'h5
`define STP_MODE_PDL_DEP  4'h8

// Dither scale per code step, in percent
`define STP_DITHER_STEP_PCT 8'h19

// Timing: figures in ns, counts in pclk cycles
`define STP_CLK_PERIOD_NS   4
`define STP_AVG_BASE_NS     80
`define STP_OVERHEAD_NS     100
`define STP_DELAY_UNIT_NS   20
`define STP_AVG_UNIT_CYC    (`STP_AVG_BASE_NS / `STP_CLK_PERIOD_NS)
`define STP_OVERHEAD_CYC    (`STP_OVERHEAD_NS / `STP_CLK_PERIOD_NS)
`define STP_DELAY_UNIT_CYC  (`STP_DELAY_UNIT_NS / `STP_CLK_PERIOD_NS)

`endif

// file: common/stp_pkg.sv
// Types shared by the SOP tracking register bank and its loop timer
package stp_pkg;

   // Loop timer phases, one-hot
   typedef enum logic [3:0] {
      STP_PH_IDLE   = 4'b0001,
      STP_PH_DELAY  = 4'b0010,
      STP_PH_AVG    = 4'b0100,
      STP_PH_SETTLE = 4'b1000
   } stp_phase_t;

   // Decoded loop mode
   typedef struct packed {
      logic idle;
      logic hold;
      logic active;
      logic pdl_ext;
      logic pdl_depol;
   } stp_mode_t;

   // Tracking settings, bit 6 down to bit 0
   typedef struct packed {
      logic       photodiode_gain_control;
      logic       ref_sensitive;
      logic       dut_sensitive;
      logic       ref_path_enable;
      logic       gradient_power_indep;
      logic [1:0] detector_mode;
   } stp_track_t;

   // Timing settings handed to the loop timer
   typedef struct packed {
      logic [3:0]  exponent;
      logic [12:0] delay;
   } stp_timing_cfg_t;

   // Software-visible register contents
   typedef struct packed {
      logic [3:0]  mode;
      logic [15:0] gain;
      logic        maximize;
      logic [3:0]  exponent;
      logic [12:0] delay;
      logic [2:0]  dither;
      logic [3:0]  pullback;
      stp_track_t  track;
      logic [7:0]  iterations;
   } stp_regs_t;

endpackage

// file: core/stp_loop_timer.sv
// Loop timer: error delay, averaging window and fixed overhead per update
`include "stp_consts.svh"
module stp_loop_timer
   import stp_pkg::*;
#(
   parameter int unsigned avg_unit_cycles   = `STP_AVG_UNIT_CYC,
   parameter int unsigned delay_unit_cycles = `STP_DELAY_UNIT_CYC
) (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            run,
   input  wire stp_timing_cfg_t cfg,
   output logic                 delay_busy,
   output logic                 sample_window,
   output logic                 update_tick
);

   stp_phase_t  phase;
   stp_phase_t  next_phase;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic [31:0] avg_len;
   logic [31:0] dly_len;
   logic        next_tick;

   // Lengths of the delay and averaging phases in cycles
   assign avg_len = 32'(avg_unit_cycles << cfg.exponent);
   assign dly_len = 32'(cfg.delay) * 32'(delay_unit_cycles);

   // Phase sequencing, restarted each update while the loop runs
   always_comb begin
      next_phase = phase;
      next_cnt   = cnt;
      next_tick  = 1'b0;
      if (!run) begin
         next_phase = STP_PH_IDLE;
         next_cnt   = 32'h0000_0000;
      end else begin
         unique case (phase)
            STP_PH_IDLE, STP_PH_SETTLE: begin
               if (phase == STP_PH_SETTLE && cnt != 32'h0000_0000) begin
                  next_cnt = cnt - 32'h0000_0001;
               end else begin
                  next_tick = (phase == STP_PH_SETTLE);
                  if (dly_len == 32'h0000_0000) begin
                     next_phase = STP_PH_AVG;
                     next_cnt   = avg_len - 32'h0000_0001;
                  end else begin
                     next_phase = STP_PH_DELAY;
                     next_cnt   = dly_len - 32'h0000_0001;
                  end
               end
            end
            STP_PH_DELAY: begin
               if (cnt == 32'h0000_0000) begin
                  next_phase = STP_PH_AVG;
                  next_cnt   = avg_len - 32'h0000_0001;
               end else begin
                  next_cnt = cnt - 32'h0000_0001;
               end
            end
            STP_PH_AVG: begin
               if (cnt == 32'h0000_0000) begin
                  next_phase = STP_PH_SETTLE;
                  next_cnt   = 32'(`STP_OVERHEAD_CYC) - 32'h0000_0001;
               end else begin
                  next_cnt = cnt - 32'h0000_0001;
               end
            end
         endcase
      end
   end

   // Phase registers and registered outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase         <= STP_PH_IDLE;
         cnt           <= 32'h0000_0000;
         delay_busy    <= 1'b0;
         sample_window <= 1'b0;
         update_tick   <= 1'b0;
      end else begin
         phase         <= next_phase;
         cnt           <= next_cnt;
         delay_busy    <= (next_phase == STP_PH_DELAY);
         sample_window <= (next_phase == STP_PH_AVG);
         update_tick   <= next_tick;
      end
   end

endmodule // stp_loop_timer

// file: core/stp_regs.sv
// SOP tracking and PDL loop control register bank with APB slave
`include "stp_consts.svh"

// Contract
// - Decode the five loop mode codes
// - Sixteen-bit loop gain, reset to 100
// - Direction bit: minimize cleared, maximize set
// - Averaging time is 80 ns times two-to-exponent
// - Update period adds fixed 100 ns overhead
// - Exponent zero fastest, fifteen slowest
// - Thirteen-bit error delay in 20 ns units
// - Dither scales 25 percent steps, default 50
// - Four-bit pull-back strength, reset to one
// - Bit 6 photodiode gain, bit 5 sensitivity
// - Eight-bit extinction iteration count
module stp_regs
   import stp_pkg::*;
#(
   parameter int unsigned avg_unit_cycles   = `STP_AVG_UNIT_CYC,
   parameter int unsigned delay_unit_cycles = `STP_DELAY_UNIT_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output stp_mode_t        mode_ctl,
   output logic [15:0]      loop_gain,
   output logic             drive_maximize,
   output logic [3:0]       averaging_exponent,
   output logic [12:0]      error_delay,
   output logic [7:0]       dither_percent,
   output logic [3:0]       pullback_strength,
   output stp_track_t       track_cfg,
   output logic [7:0]       pdl_iterations,
   output logic             delay_busy,
   output logic             sample_window,
   output logic             update_tick
);

   localparam stp_regs_t REGS_RESET = '{
      mode:       `STP_RST_MODE,
      gain:       `STP_RST_GAIN,
      maximize:   `STP_RST_DIR,
      exponent:   `STP_RST_EXP,
      delay:      `STP_RST_DELAY,
      dither:     `STP_RST_DITHER,
      pullback:   `STP_RST_PULLBACK,
      track:      `STP_RST_TRACK,
      iterations: `STP_RST_ITER
   };

   stp_regs_t       regs;
   stp_regs_t       next_regs;
   logic            next_pready;
   logic [31:0]     next_prdata;
   logic            next_pslverr;
   stp_mode_t       next_ctl;
   logic [7:0]      next_dither_pct;
   logic [9:0]      idx;
   logic            addr_hit;
   logic [31:0]     rd_word;
   logic            access;
   logic            wr_done;
   logic            run;
   stp_timing_cfg_t timing_cfg;

   // APB decode: one wait state, then the completing edge
   assign idx     = paddr[11:2];
   assign access  = psel & penable & ~pready;
   assign wr_done = psel & penable & pready & pwrite & addr_hit;

   // Address decode and read data; narrow fields sit in the low bits
   always_comb begin
      addr_hit = (paddr[1:0] == 2'h0);
      rd_word  = 32'h0000_0000;
      case (idx)
         `STP_IDX_MODE:     rd_word = {28'h0, regs.mode};
         `STP_IDX_GAIN:     rd_word = {16'h0, regs.gain};
         `STP_IDX_DIR:      rd_word = {31'h0, regs.maximize};
         `STP_IDX_EXP:      rd_word = {28'h0, regs.exponent};
         `STP_IDX_DELAY:    rd_word = {19'h0, regs.delay};
         `STP_IDX_DITHER:   rd_word = {29'h0, regs.dither};
         `STP_IDX_PULLBACK: rd_word = {28'h0, regs.pullback};
         `STP_IDX_TRACK:    rd_word = {25'h0, regs.track};
         `STP_IDX_ITER:     rd_word = {24'h0, regs.iterations};
         default:           addr_hit = 1'b0;
      endcase
      if (!addr_hit) begin
         rd_word = 32'h0000_0000;
      end
   end

   // Bus response: ready pulses for one cycle after one wait state
   always_comb begin
      next_pready  = access;
      next_prdata  = prdata;
      next_pslverr = pslverr;
      if (access) begin
         next_prdata  = rd_word;
         next_pslverr = ~addr_hit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= next_pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // Register writes take effect on the completing edge only
   always_comb begin
      next_regs = regs;
      if (wr_done) begin
         case (idx)
            `STP_IDX_MODE:     next_regs.mode       = pwdata[3:0];
            `STP_IDX_GAIN:     next_regs.gain       = pwdata[15:0];
            `STP_IDX_DIR:      next_regs.maximize   = pwdata[0];
            `STP_IDX_EXP:      next_regs.exponent   = pwdata[3:0];
            `STP_IDX_DELAY:    next_regs.delay      = pwdata[12:0];
            `STP_IDX_DITHER:   next_regs.dither     = pwdata[2:0];
            `STP_IDX_PULLBACK: next_regs.pullback   = pwdata[3:0];
            `STP_IDX_TRACK:    next_regs.track      = pwdata[6:0];
            `STP_IDX_ITER:     next_regs.iterations = pwdata[7:0];
            default:           next_regs            = regs;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         regs <= REGS_RESET;
      end else begin
         regs <= next_regs;
      end
   end

   // Mode decode; unknown codes fall back to the disabled state
   always_comb begin
      next_ctl      = '0;
      next_ctl.idle = 1'b1;
      case (regs.mode)
         `STP_MODE_OFF:     next_ctl.idle = 1'b1;
         `STP_MODE_HOLD: begin
            next_ctl.idle = 1'b0;
            next_ctl.hold = 1'b1;
         end
         `STP_MODE_TRACK: begin
            next_ctl.idle   = 1'b0;
            next_ctl.active = 1'b1;
         end
         `STP_MODE_PDL_EXT: begin
            next_ctl.idle    = 1'b0;
            next_ctl.pdl_ext = 1'b1;
         end
         `STP_MODE_PDL_DEP: begin
            next_ctl.idle      = 1'b0;
            next_ctl.pdl_depol = 1'b1;
         end
         default:           next_ctl.idle = 1'b1;
      endcase
      next_dither_pct = 8'(regs.dither * `STP_DITHER_STEP_PCT);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ctl       <= '{idle: 1'b1, default: 1'b0};
         dither_percent <= 8'h00;
      end else begin
         mode_ctl       <= next_ctl;
         dither_percent <= next_dither_pct;
      end
   end

   // Register-backed outputs
   assign loop_gain          = regs.gain;
   assign drive_maximize     = regs.maximize;
   assign averaging_exponent = regs.exponent;
   assign error_delay        = regs.delay;
   assign pullback_strength  = regs.pullback;
   assign track_cfg          = regs.track;
   assign pdl_iterations     = regs.iterations;

   // Loop timing runs in closed-loop tracking and extinction PDL
   assign run        = mode_ctl.active | mode_ctl.pdl_ext;
   assign timing_cfg = '{exponent: regs.exponent, delay: regs.delay};

   stp_loop_timer #(
      .avg_unit_cycles   (avg_unit_cycles),
      .delay_unit_cycles (delay_unit_cycles)
   ) u_timer (
      .pclk          (pclk),
      .presetn       (presetn),
      .run           (run),
      .cfg           (timing_cfg),
      .delay_busy    (delay_busy),
      .sample_window (sample_window),
      .update_tick   (update_tick)
   );

   // Checking helpers: lengths of the delay and averaging phases
   logic [31:0] win_len;
   logic [31:0] next_win_len;
   logic [31:0] busy_len;
   logic [31:0] next_busy_len;
   logic [31:0] avg_len_ref;
   logic [31:0] dly_len_ref;
   logic        mode_legal;

   always_comb begin
      next_win_len  = sample_window ? win_len + 32'h0000_0001 : 32'h0000_0000;
      next_busy_len = delay_busy ? busy_len + 32'h0000_0001 : 32'h0000_0000;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_len  <= 32'h0000_0000;
         busy_len <= 32'h0000_0000;
      end else begin
         win_len  <= next_win_len;
         busy_len <= next_busy_len;
      end
   end

   assign avg_len_ref = 32'(avg_unit_cycles << regs.exponent);
   assign dly_len_ref = 32'(regs.delay) * 32'(delay_unit_cycles);
   assign mode_legal  = (regs.mode == `STP_MODE_OFF) || (regs.mode == `STP_MODE_HOLD) ||
                        (regs.mode == `STP_MODE_TRACK) || (regs.mode == `STP_MODE_PDL_EXT) ||
                        (regs.mode == `STP_MODE_PDL_DEP);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Completing APB write to a given register index
   sequence s_apb_write(logic [9:0] idx_c);
      psel && penable && pready && pwrite && (paddr == {idx_c, 2'h0});
   endsequence

   sequence s_mode_is(logic [3:0] code_c);
      regs.mode == code_c;
   endsequence

   // Bus handshake
   chk_apb_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready did not follow the wait state");
   chk_apb_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   chk_unmapped_err: assert property (access && !addr_hit |=> pslverr && prdata == 32'h0000_0000)
      else $error("unmapped access not answered with error and zero data");

   // Mode decode
   chk_mode_track: assert property (s_mode_is(`STP_MODE_TRACK) |=> mode_ctl.active && !mode_ctl.idle)
      else $error("tracking code not decoded as active");
   chk_mode_depol: assert property (s_mode_is(`STP_MODE_PDL_DEP) |=> mode_ctl.pdl_depol && !run)
      else $error("depolarization code decoded wrongly");
   chk_illegal_idle: assert property ((!mode_legal) [*3] |-> mode_ctl.idle && !sample_window)
      else $error("undefined mode code did not leave the loop idle");

   // Register fields
   chk_gain_reset: assert property ($rose(presetn) |-> loop_gain == `STP_RST_GAIN)
      else $error("loop gain reset value wrong");
   chk_gain_write: assert property (s_apb_write(`STP_IDX_GAIN) |=> loop_gain == $past(pwdata[15:0]))
      else $error("loop gain write lost");
   chk_dir_write: assert property (s_apb_write(`STP_IDX_DIR) |=> drive_maximize == $past(pwdata[0]))
      else $error("direction bit write lost");
   chk_dither_scale: assert property (s_apb_write(`STP_IDX_DITHER) |=> ##1
         dither_percent == 8'($past(pwdata[2:0], 2) * `STP_DITHER_STEP_PCT))
      else $error("dither percentage wrong");
   chk_pullback_write: assert property (s_apb_write(`STP_IDX_PULLBACK) |=>
         pullback_strength == $past(pwdata[3:0]))
      else $error("pull-back strength write lost");
   chk_track_bits: assert property (s_apb_write(`STP_IDX_TRACK) |=>
         track_cfg.photodiode_gain_control == $past(pwdata[6]) && track_cfg.ref_sensitive == $past(pwdata[5]))
      else $error("tracking setting bits wrong");
   chk_iter_write: assert property (s_apb_write(`STP_IDX_ITER) |=> pdl_iterations == $past(pwdata[7:0]))
      else $error("iteration count write lost");

   // Loop timing
   // A window cut short by stopping the loop is not a finished window
   chk_avg_window: assert property ($fell(sample_window) && run |-> win_len == avg_len_ref)
      else $error("averaging window length wrong");
   chk_settle_gap: assert property (update_tick |-> $past(sample_window, 26) && !$past(sample_window, 25))
      else $error("update not 100 ns after averaging end");
   chk_delay_len: assert property ($fell(delay_busy) && run |-> busy_len == dly_len_ref)
      else $error("error delay length wrong");

endmodule // stp_regs

// file: tb/tb_stp_regs.sv
// Self-checking bench for the SOP tracking register bank over APB
`include "stp_consts.svh"
module tb_stp_regs
   import stp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic             pclk;
   logic             presetn;
   logic             psel;
   logic             penable;
   logic             pwrite;
   logic [11:0]      paddr;
   logic [31:0]      pwdata;
   logic             pready;
   logic [31:0]      prdata;
   logic             pslverr;
   stp_mode_t        mode_ctl;
   logic [15:0]      loop_gain;
   logic             drive_maximize;
   logic [3:0]       averaging_exponent;
   logic [12:0]      error_delay;
   logic [7:0]       dither_percent;
   logic [3:0]       pullback_strength;
   stp_track_t       track_cfg;
   logic [7:0]       pdl_iterations;
   logic             delay_busy;
   logic             sample_window;
   logic             update_tick;
   int               num_errors;
   int               cmp_count;
   logic [31:0]      rd;
   logic             err;
   int               n;
   logic [9:0]       idx_tab [9];
   logic [31:0]      rst_tab [9];
   logic [31:0]      msk_tab [9];

   // Unit timing shortened to one cycle per unit
   stp_regs #(.avg_unit_cycles(1), .delay_unit_cycles(1)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .mode_ctl(mode_ctl), .loop_gain(loop_gain), .drive_maximize(drive_maximize),
      .averaging_exponent(averaging_exponent), .error_delay(error_delay),
      .dither_percent(dither_percent), .pullback_strength(pullback_strength),
      .track_cfg(track_cfg), .pdl_iterations(pdl_iterations), .delay_busy(delay_busy),
      .sample_window(sample_window), .update_tick(update_tick)
   );

   // Clock of 4 ns period
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic print_verdict();
      if (num_errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] expv, input logic [31:0] got);
      cmp_count++;
      if (got !== expv) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, expv, got);
      end
   endtask

   // One APB transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [1:0] lo, input logic [31:0] wd);
      int k;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {idx, lo};
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer however long it takes; only the watchdog ends a hang
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1);
      check("pready_wait", 32'h2, k); // One wait state, then the completing edge
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle();
      repeat (3) @(posedge pclk);
      #1;
   endtask

   function automatic logic sel(input int w);
      return (w == 0) ? delay_busy : (w == 1) ? sample_window : update_tick;
   endfunction

   // Counts sampled cycles while the chosen output keeps a level
   task automatic count_while(input int w, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (sel(w) === lvl && cnt < lim) begin
         cnt++;
         @(posedge pclk);
         #1;
      end
   endtask

   function automatic stp_mode_t exp_mode(input logic [3:0] c);
      case (c)
         4'h0:    return 5'b10000;
         4'h1:    return 5'b01000;
         4'h3:    return 5'b00100;
         4'h5:    return 5'b00010;
         4'h8:    return 5'b00001;
         default: return 5'b10000;
      endcase
   endfunction

   // One loop period: delay phase, averaging window, fixed overhead, tick
   task automatic measure(input logic [12:0] d, input logic [3:0] e, input logic [3:0] m);
      apb(1'b1, `STP_IDX_DELAY, 2'h0, {19'h0, d});
      apb(1'b1, `STP_IDX_EXP, 2'h0, {28'h0, e});
      apb(1'b1, `STP_IDX_MODE, 2'h0, {28'h0, m});
      @(posedge pclk);
      #1;
      if (d != 13'h0000) begin
         count_while(0, 1'b0, 50, n);
         count_while(0, 1'b1, 9000, n);
         check("delay_len", {19'h0, d}, n);
      end else begin
         count_while(1, 1'b0, 50, n);
      end
      count_while(1, 1'b1, 40000, n);
      check("window_len", 32'h1 << e, n);
      count_while(2, 1'b0, 100, n);
      check("overhead_len", 32'd25, n);
      check("tick", 32'h1, {31'h0, update_tick});
      apb(1'b1, `STP_IDX_MODE, 2'h0, 32'h0);
      settle();
      check("stopped", 32'h0, {29'h0, delay_busy, sample_window, update_tick});
   endtask

   // Watchdog against a hung handshake or timer
   initial begin
      repeat (90000) @(posedge pclk);
      num_errors++;
      print_verdict();
   end

   initial begin
      idx_tab = '{`STP_IDX_ITER, `STP_IDX_MODE, `STP_IDX_GAIN, `STP_IDX_DIR, `STP_IDX_EXP,
                  `STP_IDX_DELAY, `STP_IDX_DITHER, `STP_IDX_PULLBACK, `STP_IDX_TRACK};
      rst_tab = '{32'h0, 32'h0, 32'h64, 32'h0, 32'h0, 32'h0, 32'h2, 32'h1, 32'h0};
      msk_tab = '{32'hFF, 32'hF, 32'hFFFF, 32'h1, 32'hF, 32'h1FFF, 32'h7, 32'hF, 32'h7F};
      num_errors = 0;
      cmp_count  = 0;
      presetn = 1'b0;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0000_0000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      // Outputs after reset
      check("mode_rst", 32'h10, {27'h0, mode_ctl});
      check("gain_rst", 32'h64, {16'h0, loop_gain});
      check("dither_rst", 32'd50, {24'h0, dither_percent});
      check("pull_rst", 32'h1, {28'h0, pullback_strength});
      // Register reset values, then all-ones writes trimmed to field width
      for (int i = 0; i < 9; i++) begin
         apb(1'b0, idx_tab[i], 2'h0, 32'h0);
         check("reg_rst", rst_tab[i], rd);
         apb(1'b1, idx_tab[i], 2'h0, 32'hFFFF_FFFF);
         apb(1'b0, idx_tab[i], 2'h0, 32'h0);
         check("reg_rw", msk_tab[i], rd);
         check("reg_err", 32'h0, {31'h0, err});
      end
      settle();
      check("gain_out", 32'hFFFF, {16'h0, loop_gain});
      check("max_out", 32'h1, {31'h0, drive_maximize});
      check("exp_out", 32'hF, {28'h0, averaging_exponent});
      check("delay_out", 32'h1FFF, {19'h0, error_delay});
      check("pull_out", 32'hF, {28'h0, pullback_strength});
      check("iter_out", 32'hFF, {24'h0, pdl_iterations});
      check("mode_out", 32'h10, {27'h0, mode_ctl});
      apb(1'b1, `STP_IDX_DIR, 2'h0, 32'h0);
      apb(1'b1, `STP_IDX_TRACK, 2'h0, 32'h20);
      settle();
      check("min_out", 32'h0, {31'h0, drive_maximize});
      check("ref_sens", 32'h20, {25'h0, track_cfg});
      apb(1'b1, `STP_IDX_TRACK, 2'h0, 32'h40);
      settle();
      check("pd_gain", 32'h1, {31'h0, track_cfg.photodiode_gain_control});
      check("ref_off", 32'h0, {31'h0, track_cfg.ref_sensitive});
      // Dither codes and their percentages
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, `STP_IDX_DITHER, 2'h0, 32'(c));
         settle();
         check("dither_pct", 32'(c * 25), {24'h0, dither_percent});
      end
      // Every mode code, defined and undefined
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, `STP_IDX_MODE, 2'h0, 32'(c));
         settle();
         check("mode_dec", {27'h0, exp_mode(4'(c))}, {27'h0, mode_ctl});
      end
      // Hold mode keeps the timer idle
      apb(1'b1, `STP_IDX_MODE, 2'h0, 32'h1);
      settle();
      count_while(1, 1'b0, 60, n);
      check("hold_idle", 32'd60, n);
      // Unmapped and misaligned accesses are refused
      apb(1'b0, 10'h150, 2'h0, 32'h0);
      check("unmap_err", 32'h1, {31'h0, err});
      check("unmap_data", 32'h0, rd);
      apb(1'b1, `STP_IDX_GAIN, 2'h2, 32'h1234);
      check("misal_err", 32'h1, {31'h0, err});
      apb(1'b0, `STP_IDX_GAIN, 2'h0, 32'h0);
      check("gain_kept", 32'hFFFF, rd);
      // Loop timing at several settings
      // Digital feedback settings: delay of 41 units, exponent of two
      measure(13'h0029, 4'h2, `STP_MODE_TRACK);
      measure(13'h0000, 4'hF, `STP_MODE_PDL_EXT);
      measure(13'h1FFF, 4'h0, `STP_MODE_TRACK);
      print_verdict();
   end

endmodule // tb_stp_regs
